// ==== verilog/plv_pkg.sv ====
// Operation
// R1: Tagged VID-zero frames use VID zero if null bit set, else default VID.
// R2: Ingress filter drops frames whose VLAN membership lacks ingress port.
// R3: Non-default-VID discard drops frames whose VID is not the default VID.
// R4: MAC-based 802.1X bit makes lookup authenticate; else only the ACL.
// R5: Self-address filter drops frames whose source MAC equals switch MAC.
// R6: Self-address filtering needs both port enable and global enable.
// R7: A 3-bit pointer selects which of eight instance states is accessed.
// R8: Each port keeps eight instance state bytes, chosen by the pointer.
// R9: Transmit enable allows sending if set, blocks if clear; resets one.
// R10: Receive enable allows reception if set, blocks if clear; resets one.
// R11: Instance learning disable stops source learning when set; resets zero.
// R12: Seven ports each have their own copy, chosen by upper address digit.
package plv_pkg;
    localparam int          NUM_PORTS   = 7;
    localparam int          NUM_INST    = 8;
    localparam int          PTR_W       = 3;
    localparam int          VID_W       = 12;
    localparam int          MAC_BYTES   = 6;
    localparam logic [11:0] LOC_CTRL    = 12'hb00;
    localparam logic [11:0] LOC_PTR     = 12'hb01;
    localparam logic [11:0] LOC_STATE   = 12'hb04;
    localparam logic [15:0] GLB_ADDR    = 16'h0f00;
    localparam logic [15:0] MAC_ADDR0   = 16'h0f01;
    localparam int          CTRL_NULL   = 7;
    localparam int          CTRL_INGF   = 6;
    localparam int          CTRL_NPVID  = 5;
    localparam int          CTRL_AUTH   = 4;
    localparam int          CTRL_SELF   = 3;
    localparam logic [7:0]  CTRL_WMASK  = 8'hfa;
    localparam logic [7:0]  CTRL_RST    = 8'h00;
    localparam logic [7:0]  PTR_RST     = 8'h00;
    localparam int          ST_TX       = 2;
    localparam int          ST_RX       = 1;
    localparam int          ST_NOLRN    = 0;
    localparam logic [2:0]  ST_RST      = 3'h6;
    localparam int          GLB_SELF    = 0;
    localparam logic [7:0]  GLB_RST     = 8'h00;
    localparam logic [7:0]  MAC_RST     = 8'h00;
    localparam logic [2:0]  SEL_CTRL    = 3'h1;
    localparam logic [2:0]  SEL_PTR     = 3'h2;
    localparam logic [2:0]  SEL_STATE   = 3'h4;
endpackage

// ==== verilog/plv_port_regs.sv ====
`timescale 1ns/1ps
module plv_port_regs #(
    parameter int NINST = plv_pkg::NUM_INST
) (
    input  wire logic                    clk_i,
    input  wire logic                    rst_n_i,
    input  wire logic                    wr_i,
    input  wire logic [2:0]              sel_i,
    input  wire logic [7:0]              wdata_i,
    input  wire logic [plv_pkg::PTR_W-1:0] inst_i,
    output logic      [7:0]              ctrl_o,
    output logic      [7:0]              rd_o,
    output logic      [2:0]              fst_o
);
    import plv_pkg::*;

    logic [7:0] ctrl_r;
    logic [7:0] ptr_r;
    logic [2:0] st_r [NINST];

    ////////////////////////////////////////////////////////////////////////
    // Bits 2 and 0 are read-only reserved and never store a write.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctrl_r <= CTRL_RST;
        end else if (wr_i && sel_i == SEL_CTRL) begin
            ctrl_r <= wdata_i & CTRL_WMASK;
        end
    end

    // The upper pointer bits are stored but only the low three index.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ptr_r <= PTR_RST;
        end else if (wr_i && sel_i == SEL_PTR) begin
            ptr_r <= wdata_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    for (genvar i = 0; i < NINST; i++) begin : g_inst
        always_ff @(posedge clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
                st_r[i] <= ST_RST; // [R9] [R10] [R11]
            end else if (wr_i && sel_i == SEL_STATE &&
                         ptr_r[PTR_W-1:0] == PTR_W'(i)) begin
                st_r[i] <= wdata_i[2:0]; // [R7] [R8]
            end
        end
    end

    always_comb begin
        case (sel_i)
            SEL_CTRL:  rd_o = ctrl_r;
            SEL_PTR:   rd_o = ptr_r;
            SEL_STATE: rd_o = {5'h00, st_r[ptr_r[PTR_W-1:0]]}; // [R7]
            default:   rd_o = 8'h00;
        endcase
    end

    assign ctrl_o = ctrl_r;
    assign fst_o  = st_r[inst_i];
endmodule

// ==== verilog/plv_top.sv ====
`timescale 1ns/1ps
module plv_top (
    input  wire logic                       clk_i,
    input  wire logic                       reset_n_i,
    input  wire logic [15:0]                addr_i,
    input  wire logic [7:0]                 wdata_i,
    input  wire logic                       wr_i,
    input  wire logic                       rd_i,
    output logic      [7:0]                 rdata_o,
    input  wire logic                       frm_valid_i,
    input  wire logic [2:0]                 frm_port_i,
    input  wire logic                       frm_tagged_i,
    input  wire logic [plv_pkg::VID_W-1:0]  frm_vid_i,
    input  wire logic [plv_pkg::VID_W-1:0]  frm_pvid_i,
    input  wire logic [plv_pkg::NUM_PORTS-1:0] frm_member_i,
    input  wire logic [plv_pkg::PTR_W-1:0]  frm_inst_i,
    input  wire logic [47:0]                frm_sa_i,
    output logic                            res_valid_o,
    output logic      [plv_pkg::VID_W-1:0]  res_lkup_vid_o,
    output logic                            res_drop_o,
    output logic                            res_self_drop_o,
    output logic                            res_mac_auth_o,
    output logic                            res_learn_o,
    output logic      [plv_pkg::NUM_PORTS-1:0] res_tx_mask_o
);
    import plv_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Reset release is synchronised; assertion stays asynchronous.
    // A raw release edge could let some registers leave reset a cycle early.
    logic rst_s1_r;
    logic rst_n_r;

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rst_s1_r <= 1'b0;
            rst_n_r  <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_n_r  <= rst_s1_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Decodes the in-page location into a one-hot register select.
    function automatic logic [2:0] loc_sel(input logic [15:0] a);
        case (a[11:0])
            LOC_CTRL:  loc_sel = SEL_CTRL;
            LOC_PTR:   loc_sel = SEL_PTR;
            LOC_STATE: loc_sel = SEL_STATE;
            default:   loc_sel = 3'h0;
        endcase
    endfunction

    // Port copy n answers when the upper address digit equals n plus one.
    function automatic logic port_hit(input logic [15:0] a, input int n);
        port_hit = (a[15:12] == 4'(n + 1));
    endfunction

    ////////////////////////////////////////////////////////////////////////
    logic [7:0]       ctrl_w [NUM_PORTS];
    logic [7:0]       prd_w  [NUM_PORTS];
    logic [2:0]       fst_w  [NUM_PORTS];
    logic [2:0]       sel_w  [NUM_PORTS];
    logic [PTR_W-1:0] inst_w;

    assign inst_w = frm_inst_i;

    for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
        assign sel_w[p] = port_hit(addr_i, p) ? // [R12]
                          loc_sel(addr_i) : 3'h0;

        plv_port_regs #(
            .NINST   (NUM_INST)
        ) u_regs (
            .clk_i   (clk_i),
            .rst_n_i (rst_n_r),
            .wr_i    (wr_i),
            .sel_i   (sel_w[p]),
            .wdata_i (wdata_i),
            .inst_i  (inst_w),
            .ctrl_o  (ctrl_w[p]),
            .rd_o    (prd_w[p]),
            .fst_o   (fst_w[p])
        );
    end

    ////////////////////////////////////////////////////////////////////////
    // Global lookup controls that this block depends on.
    logic [7:0] glb_r;
    logic [7:0] mac_r [MAC_BYTES];
    logic [47:0] mac_w;

    always_ff @(posedge clk_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            glb_r <= GLB_RST;
        end else if (wr_i && addr_i == GLB_ADDR) begin
            glb_r <= wdata_i;
        end
    end

    // Byte 0 is the most significant byte of the switch MAC address.
    for (genvar b = 0; b < MAC_BYTES; b++) begin : g_mac
        always_ff @(posedge clk_i or negedge rst_n_r) begin
            if (!rst_n_r) begin
                mac_r[b] <= MAC_RST;
            end else if (wr_i && addr_i == MAC_ADDR0 + 16'(b)) begin
                mac_r[b] <= wdata_i;
            end
        end
        assign mac_w[47-8*b -: 8] = mac_r[b];
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data answer exactly one cycle after the strobe.
    logic [7:0] rd_nxt;
    logic [7:0] rdata_r;

    always_comb begin
        rd_nxt = 8'h00;
        for (int p = 0; p < NUM_PORTS; p++) begin
            rd_nxt = rd_nxt | prd_w[p];
        end
        if (addr_i == GLB_ADDR) begin
            rd_nxt = glb_r;
        end
        for (int b = 0; b < MAC_BYTES; b++) begin
            if (addr_i == MAC_ADDR0 + 16'(b)) begin
                rd_nxt = mac_r[b];
            end
        end
    end

    // Data is held at zero outside the answer cycle.
    // That lets a wider bus simply OR this block with other slaves.
    always_ff @(posedge clk_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            rdata_r <= 8'h00;
        end else begin
            rdata_r <= rd_i ? rd_nxt : 8'h00;
        end
    end

    assign rdata_o = rdata_r;

    ////////////////////////////////////////////////////////////////////////
    // Frame decision. An ingress port outside 1..7 is always dropped.
    logic                 fp_ok;
    logic [2:0]           fp;
    logic [7:0]           fc;
    logic [2:0]           fs;
    logic [VID_W-1:0]     lk_vid;
    logic [VID_W-1:0]     eff_vid;
    logic                 ingf_drop;
    logic                 npvid_drop;
    logic                 self_drop;
    logic                 rx_drop;
    logic [NUM_PORTS-1:0] tx_mask;

    always_comb begin
        fp_ok = frm_port_i != 3'h0;
        fp    = fp_ok ? frm_port_i - 3'h1 : 3'h0;
        fc    = ctrl_w[fp];
        fs    = fst_w[fp];
        eff_vid = frm_pvid_i;
        lk_vid  = frm_pvid_i;
        if (frm_tagged_i && frm_vid_i != '0) begin
            eff_vid = frm_vid_i;
            lk_vid  = frm_vid_i;
        end else if (frm_tagged_i && fc[CTRL_NULL]) begin
            eff_vid = '0;
            lk_vid  = '0; // [R1]
        end
        ingf_drop  = fc[CTRL_INGF] && !frm_member_i[fp]; // [R2]
        npvid_drop = fc[CTRL_NPVID] && eff_vid != frm_pvid_i; // [R3]
        self_drop  = fc[CTRL_SELF] && glb_r[GLB_SELF] && // [R6]
                     frm_sa_i == mac_w; // [R5]
        rx_drop    = !fs[ST_RX]; // [R10]
        for (int p = 0; p < NUM_PORTS; p++) begin
            tx_mask[p] = fst_w[p][ST_TX]; // [R9]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    logic                 rv_r;
    logic [VID_W-1:0]     rvid_r;
    logic                 rdrop_r;
    logic                 rself_r;
    logic                 rauth_r;
    logic                 rlearn_r;
    logic [NUM_PORTS-1:0] rtx_r;

    always_ff @(posedge clk_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            rv_r <= 1'b0;
        end else begin
            rv_r <= frm_valid_i;
        end
    end

    // Result fields load only on a request and keep their value between lookups.
    always_ff @(posedge clk_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            rvid_r   <= '0;
            rdrop_r  <= 1'b0;
            rself_r  <= 1'b0;
            rauth_r  <= 1'b0;
            rlearn_r <= 1'b0;
            rtx_r    <= '0;
        end else if (frm_valid_i) begin
            rvid_r   <= lk_vid;
            rdrop_r  <= !fp_ok || ingf_drop || npvid_drop ||
                        self_drop || rx_drop;
            rself_r  <= fp_ok && self_drop;
            rauth_r  <= fp_ok && fc[CTRL_AUTH]; // [R4]
            rlearn_r <= fp_ok && !fs[ST_NOLRN]; // [R11]
            rtx_r    <= tx_mask; // [R9]
        end
    end

    assign res_valid_o     = rv_r;
    assign res_lkup_vid_o  = rvid_r;
    assign res_drop_o      = rdrop_r;
    assign res_self_drop_o = rself_r;
    assign res_mac_auth_o  = rauth_r;
    assign res_learn_o     = rlearn_r;
    assign res_tx_mask_o   = rtx_r;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_r);

    logic st_sel_w;
    assign st_sel_w = addr_i[11:0] == LOC_STATE && addr_i[15:12] != 4'h0 &&
                      addr_i[15:12] <= 4'(NUM_PORTS);

    property p_null_vid;
        frm_valid_i && fp_ok && frm_tagged_i && frm_vid_i == '0 &&
        fc[CTRL_NULL] |=> res_valid_o && res_lkup_vid_o == '0;
    endproperty
    a_null_vid: assert property (p_null_vid) // [R1]
        else $error("null VID frame not looked up with VID zero");

    property p_pvid;
        frm_valid_i && frm_tagged_i && frm_vid_i == '0 && !fc[CTRL_NULL]
        |=> res_lkup_vid_o == $past(frm_pvid_i);
    endproperty
    a_pvid: assert property (p_pvid) // [R1]
        else $error("null VID frame not looked up with default VID");

    property p_ingf;
        frm_valid_i && fc[CTRL_INGF] && !frm_member_i[fp] |=> res_drop_o;
    endproperty
    a_ingf: assert property (p_ingf) // [R2]
        else $error("non-member frame passed ingress filter");

    property p_npvid;
        frm_valid_i && fc[CTRL_NPVID] && frm_tagged_i &&
        frm_vid_i != '0 && frm_vid_i != frm_pvid_i |=> res_drop_o;
    endproperty
    a_npvid: assert property (p_npvid) // [R3]
        else $error("non-default VID frame not dropped");

    property p_self;
        frm_valid_i && fp_ok && fc[CTRL_SELF] && glb_r[GLB_SELF] &&
        frm_sa_i == mac_w |=> res_self_drop_o && res_drop_o;
    endproperty
    a_self: assert property (p_self) // [R5]
        else $error("own source address not dropped");

    property p_self_glb;
        res_valid_o && res_self_drop_o |-> $past(glb_r[GLB_SELF]) &&
        $past(fc[CTRL_SELF]);
    endproperty
    a_self_glb: assert property (p_self_glb) // [R6]
        else $error("self filter acted without both enables");

    property p_auth;
        frm_valid_i && fp_ok |=> res_mac_auth_o == $past(fc[CTRL_AUTH]);
    endproperty
    a_auth: assert property (p_auth) // [R4]
        else $error("authentication flag does not follow control");

    property p_st_back;
        wr_i && st_sel_w ##1 rd_i && !wr_i && addr_i == $past(addr_i)
        |=> rdata_o == ($past(wdata_i, 2) & 8'h07);
    endproperty
    a_st_back: assert property (p_st_back) // [R7] [R8]
        else $error("instance state read back differs from write");

    property p_rx;
        frm_valid_i && !fs[ST_RX] |=> res_drop_o;
    endproperty
    a_rx: assert property (p_rx) // [R10]
        else $error("frame passed with receive disabled");

    property p_learn;
        frm_valid_i && fp_ok |=> res_learn_o == !$past(fs[ST_NOLRN]);
    endproperty
    a_learn: assert property (p_learn) // [R11]
        else $error("learning flag does not follow instance state");

    property p_tx;
        frm_valid_i |=> res_tx_mask_o[0] == $past(fst_w[0][ST_TX]);
    endproperty
    a_tx: assert property (p_tx) // [R9]
        else $error("transmit mask does not follow instance state");

    property p_rd_idle;
        !rd_i |=> rdata_o == 8'h00;
    endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data outside the answer cycle");

    // A lookup answers exactly one cycle after its request, never twice.
    property p_valid;
        res_valid_o == $past(frm_valid_i);
    endproperty
    a_valid: assert property (p_valid)
        else $error("result valid does not follow the request");

    // Consumers may pick the fields up late, so they must not move
    // between lookups.
    property p_hold;
        !frm_valid_i |=> $stable(res_lkup_vid_o) && $stable(res_drop_o) &&
        $stable(res_learn_o) && $stable(res_tx_mask_o);
    endproperty
    a_hold: assert property (p_hold)
        else $error("result fields changed without a request");

    property p_port0;
        frm_valid_i && frm_port_i == 3'h0 |=> res_drop_o &&
        !res_learn_o && !res_mac_auth_o && !res_self_drop_o;
    endproperty
    a_port0: assert property (p_port0) // [R12]
        else $error("frame from an unmapped port was not refused");

    c_null: cover property (p_null_vid);
    c_self: cover property (frm_valid_i ##1 res_self_drop_o);
    c_back: cover property (wr_i && st_sel_w ##1 rd_i && st_sel_w);
    c_txoff: cover property (res_valid_o && res_tx_mask_o != '1);
    c_port0: cover property (frm_valid_i && !fp_ok ##1 res_drop_o);
endmodule

// ==== tb/plv_tb.sv ====
`timescale 1ns/1ps
module tb;
    import plv_pkg::*;
    localparam logic [47:0] SW_MAC = 48'h02a1b2c3d4e5;
    logic        clk_i;
    logic        reset_n_i;
    logic [15:0] addr_i;
    logic [7:0]  wdata_i;
    logic        wr_i;
    logic        rd_i;
    logic [7:0]  rdata_o;
    logic        frm_valid_i;
    logic [2:0]  frm_port_i;
    logic        frm_tagged_i;
    logic [11:0] frm_vid_i;
    logic [11:0] frm_pvid_i;
    logic [6:0]  frm_member_i;
    logic [2:0]  frm_inst_i;
    logic [47:0] frm_sa_i;
    logic        res_valid_o;
    logic [11:0] res_lkup_vid_o;
    logic        res_drop_o;
    logic        res_self_drop_o;
    logic        res_mac_auth_o;
    logic        res_learn_o;
    logic [6:0]  res_tx_mask_o;
    int          error_cnt;
    int          checks_done;

    plv_top plv_top_i (
        .clk_i(clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .frm_valid_i(frm_valid_i), .frm_port_i(frm_port_i),
        .frm_tagged_i(frm_tagged_i), .frm_vid_i(frm_vid_i),
        .frm_pvid_i(frm_pvid_i), .frm_member_i(frm_member_i),
        .frm_inst_i(frm_inst_i), .frm_sa_i(frm_sa_i),
        .res_valid_o(res_valid_o), .res_lkup_vid_o(res_lkup_vid_o),
        .res_drop_o(res_drop_o), .res_self_drop_o(res_self_drop_o),
        .res_mac_auth_o(res_mac_auth_o), .res_learn_o(res_learn_o),
        .res_tx_mask_o(res_tx_mask_o)
    );

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string n, input logic [47:0] seen,
                         input logic [47:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", n, exp, seen);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic bus_wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge clk_i);
        wr_i    <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe, so sample there.
    task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
        @(posedge clk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge clk_i);
        rd_i   <= 1'b0;
        #1;
        check($sformatf("rdata %h", a), rdata_o, exp);
    endtask

    // Write then read with no gap between the strobes, as the bus allows.
    task automatic wr_rd(input logic [15:0] a, input logic [7:0] d,
                         input logic [7:0] exp);
        @(posedge clk_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge clk_i);
        wr_i    <= 1'b0;
        rd_i    <= 1'b1;
        @(posedge clk_i);
        rd_i    <= 1'b0;
        #1;
        check($sformatf("wr_rd %h", a), rdata_o, exp);
    endtask

    task automatic st_wr(input logic [3:0] p, input logic [2:0] i,
                         input logic [7:0] v);
        bus_wr({p, LOC_PTR}, {5'h00, i});
        bus_wr({p, LOC_STATE}, v);
    endtask

    task automatic frame(input logic [2:0] p, input logic t,
                         input logic [11:0] vid, input logic [6:0] mem,
                         input logic [2:0] inst, input logic [47:0] sa);
        @(posedge clk_i);
        frm_valid_i  <= 1'b1;
        frm_port_i   <= p;
        frm_tagged_i <= t;
        frm_vid_i    <= vid;
        frm_pvid_i   <= 12'h005;
        frm_member_i <= mem;
        frm_inst_i   <= inst;
        frm_sa_i     <= sa;
        @(posedge clk_i);
        frm_valid_i  <= 1'b0;
        #1;
        check("res_valid", res_valid_o, 1'b1);
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        for (int p = 1; p <= 7; p += 6) begin
            rd_chk({p[3:0], LOC_CTRL}, 8'h00);
            for (int i = 0; i < 8; i++) begin
                rd_chk({p[3:0], LOC_PTR}, i[7:0]);
                rd_chk({p[3:0], LOC_STATE}, 8'h06);
                bus_wr({p[3:0], LOC_PTR}, 8'(i + 1));
            end
            bus_wr({p[3:0], LOC_PTR}, 8'h00);
        end
        $display("reset values done");
    endtask

    task automatic t_regs();
        bus_wr(16'h2b00, 8'hff);
        rd_chk(16'h2b00, 8'hfa);
        rd_chk(16'h1b00, 8'h00);
        bus_wr(16'h2b01, 8'hfb);
        rd_chk(16'h2b01, 8'hfb);
        bus_wr(16'h2b04, 8'hff);
        rd_chk(16'h2b04, 8'h07);
        bus_wr(16'h0b00, 8'hff);
        rd_chk(16'h0b00, 8'h00);
        rd_chk(16'h8b00, 8'h00);
        rd_chk(16'h2b02, 8'h00);
        st_wr(4'h2, 3'h3, 8'h06);
        bus_wr(16'h2b00, 8'h00);
        $display("register access done");
    endtask

    task automatic t_inst();
        for (int i = 0; i < 8; i++) begin
            st_wr(4'h3, i[2:0], {5'h1f, i[2:0]});
        end
        for (int i = 7; i >= 0; i--) begin
            bus_wr(16'h3b01, i[7:0]);
            rd_chk(16'h3b04, {5'h00, i[2:0]});
            bus_wr(16'h4b01, i[7:0]);
            rd_chk(16'h4b04, 8'h06);
            st_wr(4'h3, i[2:0], 8'h06);
        end
        wr_rd(16'h3b04, 8'hfd, 8'h05);
        bus_wr(16'h3b04, 8'h06);
        $display("instance states done");
    endtask

    task automatic t_vlan();
        bus_wr(16'h2b00, 8'h80);
        frame(3'h2, 1'b1, 12'h000, 7'h7f, 3'h0, 48'h0);
        check("lkup_vid", res_lkup_vid_o, 12'h000);
        bus_wr(16'h2b00, 8'h00);
        frame(3'h2, 1'b1, 12'h000, 7'h7f, 3'h0, 48'h0);
        check("lkup_vid", res_lkup_vid_o, 12'h005);
        check("drop", res_drop_o, 1'b0);
        check("auth", res_mac_auth_o, 1'b0);
        frame(3'h2, 1'b1, 12'h009, 7'h7d, 3'h0, 48'h0);
        check("lkup_vid", res_lkup_vid_o, 12'h009);
        check("drop", res_drop_o, 1'b0);
        bus_wr(16'h2b00, 8'h40);
        frame(3'h2, 1'b1, 12'h009, 7'h7d, 3'h0, 48'h0);
        check("drop", res_drop_o, 1'b1);
        frame(3'h2, 1'b1, 12'h009, 7'h02, 3'h0, 48'h0);
        check("drop", res_drop_o, 1'b0);
        bus_wr(16'h2b00, 8'h20);
        frame(3'h2, 1'b1, 12'h009, 7'h7f, 3'h0, 48'h0);
        check("drop", res_drop_o, 1'b1);
        frame(3'h2, 1'b1, 12'h005, 7'h7f, 3'h0, 48'h0);
        check("drop", res_drop_o, 1'b0);
        frame(3'h2, 1'b0, 12'h009, 7'h7f, 3'h0, 48'h0);
        check("drop", res_drop_o, 1'b0);
        bus_wr(16'h2b00, 8'h10);
        frame(3'h2, 1'b1, 12'h005, 7'h7f, 3'h0, 48'h0);
        check("auth", res_mac_auth_o, 1'b1);
        bus_wr(16'h2b00, 8'h00);
        $display("vlan handling done");
    endtask

    task automatic t_self();
        for (int i = 0; i < MAC_BYTES; i++) begin
            bus_wr(MAC_ADDR0 + 16'(i), SW_MAC[47 - 8 * i -: 8]);
        end
        bus_wr(GLB_ADDR, 8'h01);
        bus_wr(16'h2b00, 8'h08);
        frame(3'h2, 1'b1, 12'h005, 7'h7f, 3'h0, SW_MAC);
        check("self", res_self_drop_o, 1'b1);
        check("drop", res_drop_o, 1'b1);
        frame(3'h2, 1'b1, 12'h005, 7'h7f, 3'h0, SW_MAC ^ 48'h1);
        check("self", res_self_drop_o, 1'b0);
        frame(3'h3, 1'b1, 12'h005, 7'h7f, 3'h0, SW_MAC);
        check("self", res_self_drop_o, 1'b0);
        bus_wr(GLB_ADDR, 8'h00);
        frame(3'h2, 1'b1, 12'h005, 7'h7f, 3'h0, SW_MAC);
        check("self", res_self_drop_o, 1'b0);
        check("drop", res_drop_o, 1'b0);
        bus_wr(16'h2b00, 8'h00);
        $display("self filtering done");
    endtask

    task automatic t_state();
        st_wr(4'h2, 3'h5, 8'h05);
        frame(3'h2, 1'b1, 12'h005, 7'h7f, 3'h5, 48'h0);
        check("drop", res_drop_o, 1'b1);
        check("learn", res_learn_o, 1'b0);
        st_wr(4'h2, 3'h5, 8'h02);
        frame(3'h2, 1'b1, 12'h005, 7'h7f, 3'h5, 48'h0);
        check("drop", res_drop_o, 1'b0);
        check("learn", res_learn_o, 1'b1);
        check("tx_mask", res_tx_mask_o, 7'h7d);
        frame(3'h2, 1'b1, 12'h005, 7'h7f, 3'h4, 48'h0);
        check("tx_mask", res_tx_mask_o, 7'h7f);
        st_wr(4'h2, 3'h5, 8'h06);
        frame(3'h0, 1'b1, 12'h005, 7'h7f, 3'h0, 48'h0);
        check("drop", res_drop_o, 1'b1);
        $display("spanning states done");
    endtask

    task automatic t_rst2();
        bus_wr(16'h5b00, 8'hf8);
        st_wr(4'h5, 3'h2, 8'h01);
        @(posedge clk_i);
        reset_n_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        reset_n_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rd_chk(16'h5b00, 8'h00);
        rd_chk(16'h5b01, 8'h00);
        bus_wr(16'h5b01, 8'h02);
        rd_chk(16'h5b04, 8'h06);
        $display("mid-run reset done");
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        #500us;
        error_cnt++;
        wrap_up();
    end

    initial begin
        error_cnt = 0;
        checks_done = 0;
        reset_n_i = 1'b0;
        {addr_i, wdata_i, wr_i, rd_i, frm_valid_i} = '0;
        {frm_port_i, frm_tagged_i, frm_vid_i, frm_pvid_i} = '0;
        {frm_member_i, frm_inst_i, frm_sa_i} = '0;
        repeat (2) @(posedge clk_i);
        reset_n_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        t_reset();
        t_regs();
        t_inst();
        t_vlan();
        t_self();
        t_state();
        t_rst2();
        wrap_up();
    end
endmodule
